// >>> shared/hdc_pkg.sv
// Constants and register map of the hub device configuration registers
// ==========================================================
// Notes on behaviour
// - Product identifier high byte is read/write unless both OTP ids are non-zero.
// - With both OTP identifiers non-zero, reads return the OTP high byte.
// - Bit 7, reset 0, lets string, length and language registers be written.
// - Bit 6, reset 0, lets serial number string and length be written.
// - Bit 5 set blocks U1/U2 on all ports until forced accept message.
// - After forced accept message, U1/U2 stay enabled until reset or disconnect.
// - In I2C mode bits 5, 3 and 2 load from EEPROM contents.
// - In SMBus mode the SMBus host may overwrite bits 5, 3 and 2.
// - Bit 4 is read-only and always reads 1.
// - Bit 3, ganged power, is taken from the gang strap at reset release.
// - Bits 2 and 3 clear: each port has its own power control output.
// - Bit 2 clear, bit 3 set: all ports ganged on the port-1 output.
// - Bit 2 is taken from the power report strap at reset release.
// - Bit 2 clear reports port power switching status; set does not.
// - Bit 0 is read-only and always reads 0.
package hdc_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_PRODUCT_HIGH = 8'h04;
   localparam logic [7:0] ADDR_DEV_CFG = 8'h05;
   localparam logic [7:0] ADDR_SERIAL_LO = 8'h30;
   localparam logic [7:0] ADDR_SERIAL_HI = 8'h4F;
   localparam logic [7:0] ADDR_STRING_LO = 8'h50;
   localparam logic [7:0] ADDR_STRING_HI = 8'hCF;
   // ==========================================================
   // Device configuration fields
   localparam int BIT_STRING_WE = 7;
   localparam int BIT_SERIAL_WE = 6;
   localparam int BIT_LP_DISABLE = 5;
   localparam int BIT_RSVD_ONE = 4;
   localparam int BIT_GANG = 3;
   localparam int BIT_REPORT_DIS = 2;
   localparam int BIT_RSVD_STORE = 1;
   localparam int BIT_RSVD_ZERO = 0;
   localparam logic [7:0] DEV_CFG_RESET = 8'h10;
   localparam logic [7:0] DEV_CFG_WR_MASK = 8'hEE;
   localparam logic [7:0] DEV_CFG_FORCE_ONE = 8'h10;
   localparam logic [7:0] DEV_CFG_LOAD_MASK = 8'h2C;
   // ==========================================================
   // Timing
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
endpackage

// >>> shared/hdc_mem_if.sv
// Port between the configuration logic and the string memory
`timescale 1ns/10ps
interface hdc_mem_if #(
   parameter int AW = 8,
   parameter int DW = 8
);
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport ctrl (
      output we,
      output waddr,
      output wdata,
      output raddr,
      input rdata
   );
   modport mem (
      input we,
      input waddr,
      input wdata,
      input raddr,
      output rdata
   );
endinterface

// >>> verilog/hdc_string_mem.sv
// Byte memory for string and serial number registers, registered read
`timescale 1ns/10ps
module hdc_string_mem #(
   parameter int DEPTH = 256,
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   hdc_mem_if.mem bus
);
   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] cells;
      logic [DW-1:0] rdata;
   } hdc_mem_state_t;

   hdc_mem_state_t r_reg;
   hdc_mem_state_t r_next;

   // ==========================================================
   // Next state
   always_comb begin
      r_next = r_reg;
      // Read sees old data on a same-address write
      r_next.rdata = r_reg.cells[bus.raddr];
      if (bus.we) begin
         r_next.cells[bus.waddr] = bus.wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign bus.rdata = r_reg.rdata;
endmodule

// >>> verilog/hdc_config_regs.sv
// Device configuration and product identifier high byte registers
`timescale 1ns/10ps
module hdc_config_regs #(
   parameter int NUM_PORTS = 4,
   parameter logic [7:0] PRODUCT_HIGH_DEFAULT = 8'h3C
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic smbus_mode,
   input wire logic cfg_src_eeprom,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic [15:0] otp_vendor_id,
   input wire logic [15:0] otp_product_id,
   input wire logic gang_strap_pin,
   input wire logic power_report_strap_pin,
   input wire logic pm_accept_rx,
   input wire logic pm_accept_tx,
   input wire logic upstream_disconnect,
   input wire logic [NUM_PORTS-1:0] port_power_request,
   output logic [NUM_PORTS-1:0] port_power_control_outputs,
   output logic low_power_link_allowed,
   output logic string_write_enable,
   output logic serial_write_enable,
   output logic gang_mode,
   output logic power_report_disable
);
   // PRODUCT_HIGH_DEFAULT: value is arbitrary

   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [1:0] settle_cnt;
      logic strapped;
      logic [7:0] dev_cfg;
      logic [7:0] prod_high;
      logic forced_pm;
      logic lp_allowed;
      logic rd_pend;
      logic [7:0] rd_addr;
      logic [7:0] rdata;
      logic rvalid;
      logic [NUM_PORTS-1:0] pwr_ctl;
   } hdc_state_t;

   hdc_state_t r_reg;
   hdc_state_t r_next;

   hdc_mem_if #(.AW(8), .DW(8)) mem_bus ();

   logic otp_override;
   logic wr_ok;
   logic in_serial;
   logic in_string;
   logic [7:0] otp_high;
   logic [7:0] cfg_wbits;

   // ==========================================================
   // Write qualification
   // Only the party owning the current mode may write
   assign wr_ok = cfg_wr && (smbus_mode ? !cfg_src_eeprom : cfg_src_eeprom);
   assign otp_override = (otp_vendor_id != 16'h0000) &&
                         (otp_product_id != 16'h0000);
   assign otp_high = otp_product_id[15:8];
   assign cfg_wbits = cfg_wdata & hdc_pkg::DEV_CFG_LOAD_MASK;
   assign in_serial = (cfg_addr >= hdc_pkg::ADDR_SERIAL_LO) &&
                      (cfg_addr <= hdc_pkg::ADDR_SERIAL_HI);
   assign in_string = (cfg_addr >= hdc_pkg::ADDR_STRING_LO) &&
                      (cfg_addr <= hdc_pkg::ADDR_STRING_HI);

   // ==========================================================
   // String memory port
   assign mem_bus.we = wr_ok &&
      ((in_serial && r_reg.dev_cfg[hdc_pkg::BIT_SERIAL_WE]) ||
       (in_string && r_reg.dev_cfg[hdc_pkg::BIT_STRING_WE]));
   assign mem_bus.waddr = cfg_addr;
   assign mem_bus.wdata = cfg_wdata;
   assign mem_bus.raddr = cfg_addr;

   hdc_string_mem #(.DEPTH(256), .AW(8), .DW(8)) u_mem (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bus(mem_bus.mem)
   );

   // ==========================================================
   // Next state
   always_comb begin
      r_next = r_reg;
      // Straps pass two flip-flops before they are used
      r_next.sync1 = {power_report_strap_pin, gang_strap_pin};
      r_next.sync2 = r_reg.sync1;
      if (!r_reg.strapped) begin
         if (r_reg.settle_cnt == hdc_pkg::STRAP_SETTLE) begin
            r_next.dev_cfg[hdc_pkg::BIT_GANG] = r_reg.sync2[0];
            r_next.dev_cfg[hdc_pkg::BIT_REPORT_DIS] = r_reg.sync2[1];
            r_next.strapped = 1'b1;
         end else begin
            r_next.settle_cnt = r_reg.settle_cnt + 2'h1;
         end
      end
      // Mode-qualified load or overwrite; bit 4 forced 1, bit 0 forced 0
      if (wr_ok && cfg_addr == hdc_pkg::ADDR_DEV_CFG) begin
         r_next.dev_cfg = (cfg_wdata & hdc_pkg::DEV_CFG_WR_MASK) |
                          hdc_pkg::DEV_CFG_FORCE_ONE;
      end
      if (wr_ok && cfg_addr == hdc_pkg::ADDR_PRODUCT_HIGH &&
          !otp_override) begin
         r_next.prod_high = cfg_wdata;
      end
      // Set wins over a disconnect in the same cycle
      if (pm_accept_rx || pm_accept_tx) begin
         r_next.forced_pm = 1'b1;
      end else if (upstream_disconnect) begin
         r_next.forced_pm = 1'b0;
      end
      r_next.lp_allowed = !r_next.dev_cfg[hdc_pkg::BIT_LP_DISABLE] ||
                          r_next.forced_pm;
      // Power switching follows the current gang bit
      if (r_reg.dev_cfg[hdc_pkg::BIT_GANG]) begin
         r_next.pwr_ctl = '0;
         r_next.pwr_ctl[0] = port_power_request[0];
      end else begin
         r_next.pwr_ctl = port_power_request;
      end
      // Two-cycle read: memory register, then output register
      r_next.rd_pend = cfg_rd;
      r_next.rd_addr = cfg_addr;
      r_next.rvalid = r_reg.rd_pend;
      if (r_reg.rd_pend) begin
         if (r_reg.rd_addr == hdc_pkg::ADDR_DEV_CFG) begin
            r_next.rdata = r_reg.dev_cfg;
         end else if (r_reg.rd_addr == hdc_pkg::ADDR_PRODUCT_HIGH) begin
            r_next.rdata = otp_override ? otp_high : r_reg.prod_high;
         end else if ((r_reg.rd_addr >= hdc_pkg::ADDR_SERIAL_LO) &&
                      (r_reg.rd_addr <= hdc_pkg::ADDR_STRING_HI)) begin
            r_next.rdata = mem_bus.rdata;
         end else begin
            r_next.rdata = 8'h00;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         r_reg <= '0;
         r_reg.dev_cfg <= hdc_pkg::DEV_CFG_RESET;
         r_reg.prod_high <= PRODUCT_HIGH_DEFAULT;
         r_reg.lp_allowed <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================================
   // Outputs
   assign cfg_rdata = r_reg.rdata;
   assign cfg_rvalid = r_reg.rvalid;
   assign port_power_control_outputs = r_reg.pwr_ctl;
   assign low_power_link_allowed = r_reg.lp_allowed;
   assign string_write_enable = r_reg.dev_cfg[hdc_pkg::BIT_STRING_WE];
   assign serial_write_enable = r_reg.dev_cfg[hdc_pkg::BIT_SERIAL_WE];
   assign gang_mode = r_reg.dev_cfg[hdc_pkg::BIT_GANG];
   // Status reporting is suppressed while this bit is set
   assign power_report_disable = r_reg.dev_cfg[hdc_pkg::BIT_REPORT_DIS];

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   prod_write_a: assert property (
      wr_ok && cfg_addr == hdc_pkg::ADDR_PRODUCT_HIGH && !otp_override
      |=> r_reg.prod_high == $past(cfg_wdata))
      else $error("product high byte write lost");

   otp_read_a: assert property (
      cfg_rd && cfg_addr == hdc_pkg::ADDR_PRODUCT_HIGH && otp_override
      ##1 otp_override
      |=> cfg_rvalid && cfg_rdata == $past(otp_high))
      else $error("product high byte read ignored OTP value");

   string_gate_a: assert property (
      mem_bus.we && in_string |-> string_write_enable)
      else $error("string written while locked");

   serial_gate_a: assert property (
      mem_bus.we && in_serial |-> serial_write_enable)
      else $error("serial number written while locked");

   lp_block_a: assert property (
      r_reg.dev_cfg[hdc_pkg::BIT_LP_DISABLE] && !r_reg.forced_pm
      |-> !low_power_link_allowed)
      else $error("low power link allowed while disabled");

   forced_hold_a: assert property (
      (pm_accept_rx || pm_accept_tx) ##1 !upstream_disconnect [*3]
      |-> low_power_link_allowed)
      else $error("low power link dropped after forced accept");

   i2c_load_a: assert property (
      cfg_wr && cfg_src_eeprom && !smbus_mode &&
      cfg_addr == hdc_pkg::ADDR_DEV_CFG
      |=> (r_reg.dev_cfg & hdc_pkg::DEV_CFG_LOAD_MASK) == $past(cfg_wbits))
      else $error("EEPROM load of configuration bits lost");

   smbus_write_a: assert property (
      cfg_wr && !cfg_src_eeprom && smbus_mode &&
      cfg_addr == hdc_pkg::ADDR_DEV_CFG
      |=> (r_reg.dev_cfg & hdc_pkg::DEV_CFG_LOAD_MASK) == $past(cfg_wbits))
      else $error("SMBus write of configuration bits lost");

   rsvd_bits_a: assert property (
      cfg_rd && cfg_addr == hdc_pkg::ADDR_DEV_CFG
      |-> ##2 cfg_rvalid && cfg_rdata[hdc_pkg::BIT_RSVD_ONE] &&
              !cfg_rdata[hdc_pkg::BIT_RSVD_ZERO])
      else $error("reserved configuration bits read wrong");

   strap_take_a: assert property (
      $rose(r_reg.strapped) && !$past(wr_ok)
      |-> r_reg.dev_cfg[hdc_pkg::BIT_GANG] == $past(r_reg.sync2[0]) &&
          r_reg.dev_cfg[hdc_pkg::BIT_REPORT_DIS] == $past(r_reg.sync2[1]))
      else $error("strap value not captured");

   individual_pwr_a: assert property (
      !gang_mode && !power_report_disable
      |=> port_power_control_outputs == $past(port_power_request))
      else $error("individual port power wrong");

   ganged_pwr_a: assert property (
      gang_mode && !power_report_disable
      |=> port_power_control_outputs[NUM_PORTS-1:1] == '0 &&
          port_power_control_outputs[0] == $past(port_power_request[0]))
      else $error("ganged port power wrong");
endmodule

// >>> sim/hdc_cfg_host.sv
// Host model on the register port: EEPROM loader or SMBus host
`timescale 1ns/10ps
module hdc_cfg_host (
   input wire logic clk_sys,
   input wire logic smbus_mode,
   input wire logic [7:0] cfg_rdata,
   input wire logic cfg_rvalid,
   output logic cfg_wr,
   output logic cfg_rd,
   output logic cfg_src_eeprom,
   output logic [7:0] cfg_addr,
   output logic [7:0] cfg_wdata
);
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_src_eeprom = 1'b0;
      cfg_addr = 8'h00;
      cfg_wdata = 8'h00;
   end
   // ==========================================================
   // Bus cycles
   // Bad set sends the write from the party the mode does not allow
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic bad);
      @(negedge clk_sys);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_src_eeprom = ~smbus_mode ^ bad;
      cfg_wdata = (a == 8'h05) ? (d & 8'hFD) : d;
      @(negedge clk_sys);
      cfg_wr = 1'b0;
      // Released lines show the inverse, never a stale value
      cfg_addr = ~a;
      cfg_wdata = ~cfg_wdata;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(negedge clk_sys);
      cfg_rd = 1'b1;
      cfg_addr = a;
      @(negedge clk_sys);
      cfg_rd = 1'b0;
      cfg_addr = ~a;
      d = 8'hxx;
      for (n = 0; n < 4 && cfg_rvalid !== 1'b1; n++) begin
         @(negedge clk_sys);
      end
      if (cfg_rvalid === 1'b1) begin
         d = cfg_rdata;
      end
   endtask
endmodule

// >>> sim/hub_device_config_regs_bench.sv
// Self-checking bench of the hub device configuration registers
`timescale 1ns/10ps
module hub_device_config_regs_bench;
   localparam logic [7:0] PH = 8'h3C;
   logic clk_sys, rst_n, smbus_mode, cfg_wr, cfg_rd, cfg_src_eeprom;
   logic cfg_rvalid, pm_accept_rx, pm_accept_tx, upstream_disconnect;
   logic gang_strap_pin, power_report_strap_pin, low_power_link_allowed;
   logic string_write_enable, serial_write_enable, gang_mode;
   logic power_report_disable;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, v, d, a;
   logic [15:0] otp_vendor_id, otp_product_id;
   logic [3:0] port_power_request, port_power_control_outputs;
   int errors, comparisons, seed;

   hdc_config_regs #(.NUM_PORTS(4), .PRODUCT_HIGH_DEFAULT(PH))
      hdc_config_regs_inst (.clk_sys, .rst_n, .smbus_mode, .cfg_src_eeprom,
      .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
      .otp_vendor_id, .otp_product_id, .gang_strap_pin,
      .power_report_strap_pin, .pm_accept_rx, .pm_accept_tx,
      .upstream_disconnect, .port_power_request, .port_power_control_outputs,
      .low_power_link_allowed, .string_write_enable, .serial_write_enable,
      .gang_mode, .power_report_disable);
   hdc_cfg_host host (.clk_sys, .smbus_mode, .cfg_rdata, .cfg_rvalid,
      .cfg_wr, .cfg_rd, .cfg_src_eeprom, .cfg_addr, .cfg_wdata);

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // ==========================================================
   // Checking and expectations
   task automatic chk(input string n, input logic [15:0] s,
                      input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Bit 4 forced to 1, bit 0 to 0; the host keeps bit 1 at 0
   function automatic logic [7:0] cfg_exp(input logic [7:0] w);
      return (w & 8'hEC) | 8'h10;
   endfunction
   function automatic logic [3:0] pwr_exp(input logic g, input logic [3:0] r);
      return g ? {3'b000, r[0]} : r;
   endfunction
   task automatic cfg_chk(input logic [7:0] w);
      chk("string_we", {15'h0000, string_write_enable}, {15'h0000, w[7]});
      chk("serial_we", {15'h0000, serial_write_enable}, {15'h0000, w[6]});
      chk("lp_allowed", {15'h0000, low_power_link_allowed}, {15'h0000, ~w[5]});
      chk("gang", {15'h0000, gang_mode}, {15'h0000, w[3]});
      chk("report_dis", {15'h0000, power_report_disable}, {15'h0000, w[2]});
      host.rd(8'h05, v);
      chk("dev_cfg", {8'h00, v}, {8'h00, w});
      port_power_request = 4'($random(seed));
      @(negedge clk_sys);
      chk("power", {12'h000, port_power_control_outputs},
          {12'h000, pwr_exp(w[3], port_power_request)});
   endtask

   initial begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      summarize();
   end
   // ==========================================================
   // Main sequence
   initial begin
      seed = 32'hbc96_a1e2;
      errors = 0;
      comparisons = 0;
      rst_n = 1'b0;
      smbus_mode = 1'b1;
      otp_vendor_id = 16'h0000;
      otp_product_id = 16'h0000;
      {pm_accept_rx, pm_accept_tx, upstream_disconnect} = 3'b000;
      port_power_request = 4'h0;
      gang_strap_pin = 1'($random(seed));
      power_report_strap_pin = 1'($random(seed));
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      cfg_chk({4'h1, gang_strap_pin, power_report_strap_pin, 2'b00});
      host.rd(8'h04, v);
      chk("product_dflt", {8'h00, v}, {8'h00, PH});
      host.rd(8'hF8, v);
      chk("unmapped", {8'h00, v}, 16'h0000);
      $display("Test reset done");
      d = 8'($random(seed));
      host.wr(8'h04, d, 1'b0);
      host.rd(8'h04, v);
      chk("product_wr", {8'h00, v}, {8'h00, d});
      otp_vendor_id = 16'($random(seed)) | 16'h0001;
      otp_product_id = 16'($random(seed)) | 16'h0100;
      host.rd(8'h04, v);
      chk("product_otp", {8'h00, v}, {8'h00, otp_product_id[15:8]});
      host.wr(8'h04, ~d, 1'b0);
      otp_vendor_id = 16'h0000;
      host.rd(8'h04, v);
      chk("product_kept", {8'h00, v}, {8'h00, d});
      $display("Test product byte done");
      for (int i = 0; i < 12; i++) begin
         smbus_mode = 1'($random(seed));
         d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
         host.wr(8'h05, d, 1'b0);
         cfg_chk(cfg_exp(d));
         host.wr(8'h05, ~d, 1'b1);
         cfg_chk(cfg_exp(d));
      end
      $display("Test configuration byte done");
      for (int i = 0; i < 2; i++) begin
         host.wr(8'h05, 8'h20, 1'b0);
         chk("lp_block", {15'h0000, low_power_link_allowed}, 16'h0000);
         {pm_accept_tx, pm_accept_rx} = 2'b01 << i;
         @(negedge clk_sys);
         {pm_accept_tx, pm_accept_rx} = 2'b00;
         host.wr(8'h05, 8'h20, 1'b0);
         chk("lp_forced", {15'h0000, low_power_link_allowed}, 16'h0001);
         upstream_disconnect = 1'b1;
         @(negedge clk_sys);
         upstream_disconnect = 1'b0;
         @(negedge clk_sys);
         chk("lp_cleared", {15'h0000, low_power_link_allowed}, 16'h0000);
      end
      $display("Test forced accept done");
      // Mid-run reset must drop a forced accept and restore defaults
      pm_accept_rx = 1'b1;
      @(negedge clk_sys);
      pm_accept_rx = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      host.rd(8'h04, v);
      chk("product_reset", {8'h00, v}, {8'h00, PH});
      host.wr(8'h05, 8'h20, 1'b0);
      chk("lp_reset", {15'h0000, low_power_link_allowed}, 16'h0000);
      $display("Test mid-run reset done");
      for (int i = 0; i < 2; i++) begin
         a = i ? 8'hCF : 8'h30;
         d = 8'($random(seed)) | 8'h01;
         host.wr(8'h05, 8'h00, 1'b0);
         host.wr(a, d, 1'b0);
         host.rd(a, v);
         chk("string_locked", {8'h00, v}, 16'h0000);
         host.wr(8'h05, i ? 8'h80 : 8'h40, 1'b0);
         host.wr(a, d, 1'b0);
         host.rd(a, v);
         chk("string_open", {8'h00, v}, {8'h00, d});
      end
      $display("Test string gating done");
      summarize();
   end
endmodule
